// ===== hdl/adc_ctrl_pkg.sv
// Package: register map, field layout and types of the converter control
package adc_ctrl_pkg;

  localparam int BUS_ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_SC1 = 8'h00;
  localparam logic [7:0] OFS_SC2 = 8'h04;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_COMPARE = 8'h18;
  localparam logic [7:0] OFS_MODE = 8'h1c;

  // First status/control register fields
  localparam int SC1_FLAG_BIT = 7;
  localparam int SC1_IRQEN_BIT = 6;
  localparam int SC1_CONT_BIT = 5;
  localparam int SC1_CHAN_MSB = 4;
  localparam logic [7:0] SC1_RESET = 8'h1f;

  // Second status/control register fields
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_TRIG_BIT = 6;
  localparam int SC2_CMPEN_BIT = 5;
  localparam int SC2_CMPGE_BIT = 4;
  localparam logic [2:0] SC2_RESET = 3'h0;

  // Channel codes
  localparam logic [4:0] CHAN_LAST_INPUT = 5'h1b;
  localparam logic [4:0] CHAN_RESERVED = 5'h1c;
  localparam logic [4:0] CHAN_REF_HIGH = 5'h1d;
  localparam logic [4:0] CHAN_REF_LOW = 5'h1e;
  localparam logic [4:0] CHAN_OFF = 5'h1f;

  // Conversion modes
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;

  localparam int RESULT_W = 12;
  localparam logic [RESULT_W-1:0] COMPARE_RESET = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic inputSel;
    logic highRef;
    logic lowRef;
    logic reserved;
    logic isolate;
    logic [4:0] index;
  } chan_route_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic powerOn;
    logic lowPower;
  } conv_ctl_t;

endpackage

// ===== hdl/adc_conversion_control.sv
// Converter control and status logic with an AHB-Lite register slave
// Contract
// - Writing first register aborts, restarts unless channel off
// - Compare off: completion sets done flag
// - Compare on: done flag only when compare true
// - First register write or low read clears flag
// - Flag set with interrupt enable raises interrupt; code also needs the done bit set in the interrupt mask register
// - Continuous off: one conversion per trigger
// - Continuous on: convert repeatedly after trigger
// - Decode channel field into inputs and references
// - Channel all ones: off, isolated, no conversion
// - Not continuous: low power after completion
// - Active bit set at start, cleared at end
// - Trigger select picks software or hardware start
// - Compare enable bit switches compare function
// - Direction bit: less-than or greater-or-equal
// - Load result unless compare enabled and false
// - High read locks results until low read; code locks only in 12-bit and 10-bit modes, not in 8-bit mode
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input wire logic clk_sys, // Bus clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic hwTriggerInput, // Hardware trigger from periodic counter
  input wire logic convDone, // Converter finished, one-cycle pulse
  input wire logic [RESULT_W-1:0] convData, // Raw converter result
  output conv_ctl_t convCtl, // Start, abort and power to the converter
  output chan_route_t chanRoute, // Decoded input routing
  output logic irq // Level interrupt
);

  // Bus pipeline
  logic wrPend_ff, nxt_wrPend;
  logic [BUS_ADDR_W-1:0] wrAddr_ff, nxt_wrAddr;
  logic rdStage_ff, nxt_rdStage;
  logic rdOut_ff, nxt_rdOut;
  logic [BUS_ADDR_W-1:0] rdAddr_ff, nxt_rdAddr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic accept;
  logic [31:0] readMux;

  // Registers
  logic flag_ff, nxt_flag;
  logic irqEn_ff, nxt_irqEn;
  logic cont_ff, nxt_cont;
  logic [4:0] chan_ff, nxt_chan;
  logic trigSel_ff, nxt_trigSel;
  logic cmpEn_ff, nxt_cmpEn;
  logic cmpGe_ff, nxt_cmpGe;
  logic [RESULT_W-1:0] compare_ff, nxt_compare;
  logic [1:0] mode_ff, nxt_mode;
  logic [RESULT_W-1:0] result_ff, nxt_result;
  logic interlock_ff, nxt_interlock;
  logic [IRQ_W-1:0] irqStatus_ff, nxt_irqStatus;
  logic [IRQ_W-1:0] irqMask_ff, nxt_irqMask;

  // Trigger synchroniser
  logic trgMeta_ff, trgSync_ff, trgStage3_ff, trgLevel_ff;
  logic nxt_trgLevel;
  logic trgEdge;

  // Conversion control
  conv_state_t state_ff, nxt_state;
  conv_ctl_t convCtl_ff, nxt_convCtl;
  chan_route_t route_ff, nxt_route;

  logic wrSc1, wrSc2, wrIrqStatus, wrIrqMask, wrCompare, wrMode;
  logic rdLow, rdHigh;
  logic [4:0] wrChan;
  logic finish, cmpTrue, accepted;
  logic [RESULT_W-1:0] modeData, modeCompare;
  logic [IRQ_W-1:0] irqEvents;

  // ---------------- Bus slave ----------------
  assign accept = hsel && hready && htrans[1];
  assign hreadyout = !rdStage_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  assign wrSc1 = wrPend_ff && (wrAddr_ff == OFS_SC1);
  assign wrSc2 = wrPend_ff && (wrAddr_ff == OFS_SC2);
  assign wrIrqStatus = wrPend_ff && (wrAddr_ff == OFS_IRQ_STATUS);
  assign wrIrqMask = wrPend_ff && (wrAddr_ff == OFS_IRQ_MASK);
  assign wrCompare = wrPend_ff && (wrAddr_ff == OFS_COMPARE);
  assign wrMode = wrPend_ff && (wrAddr_ff == OFS_MODE);
  assign rdLow = rdStage_ff && (rdAddr_ff == OFS_RESULT_LOW);
  assign rdHigh = rdStage_ff && (rdAddr_ff == OFS_RESULT_HIGH);
  assign wrChan = hwdata[SC1_CHAN_MSB:0];

  always_comb begin
    readMux = 32'h0000_0000;
    if (rdAddr_ff == OFS_SC1) begin
      readMux[7:0] = {flag_ff, irqEn_ff, cont_ff, chan_ff};
    end else if (rdAddr_ff == OFS_SC2) begin
      // Reserved bits 3:0 read as zero
      readMux[SC2_ACTIVE_BIT] = (state_ff == ST_CONV);
      readMux[SC2_TRIG_BIT] = trigSel_ff;
      readMux[SC2_CMPEN_BIT] = cmpEn_ff;
      readMux[SC2_CMPGE_BIT] = cmpGe_ff;
    end else if (rdAddr_ff == OFS_RESULT_HIGH) begin
      readMux[3:0] = result_ff[11:8];
    end else if (rdAddr_ff == OFS_RESULT_LOW) begin
      readMux[7:0] = result_ff[7:0];
    end else if (rdAddr_ff == OFS_IRQ_STATUS) begin
      readMux[IRQ_W-1:0] = irqStatus_ff;
    end else if (rdAddr_ff == OFS_IRQ_MASK) begin
      readMux[IRQ_W-1:0] = irqMask_ff;
    end else if (rdAddr_ff == OFS_COMPARE) begin
      readMux[RESULT_W-1:0] = compare_ff;
    end else if (rdAddr_ff == OFS_MODE) begin
      readMux[1:0] = mode_ff;
    end
  end

  // Reads take one wait state so that hrdata comes from a flop
  always_comb begin
    nxt_wrPend = accept && hwrite;
    nxt_wrAddr = accept ? haddr[BUS_ADDR_W-1:0] : wrAddr_ff;
    nxt_rdStage = accept && !hwrite;
    nxt_rdAddr = (accept && !hwrite) ? haddr[BUS_ADDR_W-1:0] : rdAddr_ff;
    nxt_rdOut = rdStage_ff;
    nxt_hrdata = rdStage_ff ? readMux : hrdata_ff;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= '0;
      rdStage_ff <= 1'b0;
      rdOut_ff <= 1'b0;
      rdAddr_ff <= '0;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wrPend_ff <= nxt_wrPend;
      wrAddr_ff <= nxt_wrAddr;
      rdStage_ff <= nxt_rdStage;
      rdOut_ff <= nxt_rdOut;
      rdAddr_ff <= nxt_rdAddr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ---------------- Hardware trigger ----------------
  // A change is taken once the second and third stages agree
  always_comb begin
    nxt_trgLevel = (trgSync_ff == trgStage3_ff) ? trgStage3_ff : trgLevel_ff;
    trgEdge = (trgSync_ff == trgStage3_ff) && trgStage3_ff && !trgLevel_ff;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trgMeta_ff <= 1'b0;
      trgSync_ff <= 1'b0;
      trgStage3_ff <= 1'b0;
      trgLevel_ff <= 1'b0;
    end else begin
      trgMeta_ff <= hwTriggerInput;
      trgSync_ff <= trgMeta_ff;
      trgStage3_ff <= trgSync_ff;
      trgLevel_ff <= nxt_trgLevel;
    end
  end

  // ---------------- Result path and compare ----------------
  always_comb begin
    case (mode_ff)
      MODE_12: begin
        modeData = convData;
        modeCompare = compare_ff;
      end
      MODE_10: begin
        modeData = {2'h0, convData[9:0]};
        modeCompare = {2'h0, compare_ff[9:0]};
      end
      default: begin
        modeData = {4'h0, convData[7:0]};
        modeCompare = {4'h0, compare_ff[7:0]};
      end
    endcase
    cmpTrue = cmpGe_ff ? (modeData >= modeCompare)
                       : (modeData < modeCompare);
    // A write to the first register in the same cycle aborts the result
    finish = convDone && (state_ff == ST_CONV) && !wrSc1;
    accepted = finish && (!cmpEn_ff || cmpTrue);
  end

  always_comb begin
    nxt_result = result_ff;
    if (accepted && !interlock_ff) begin
      nxt_result = modeData;
    end
    nxt_interlock = interlock_ff;
    if (rdLow) begin
      nxt_interlock = 1'b0;
    end else if (rdHigh && (mode_ff == MODE_12 || mode_ff == MODE_10)) begin
      nxt_interlock = 1'b1;
    end
    // Set wins over clear
    nxt_flag = accepted || (flag_ff && !(wrSc1 || rdLow));
  end

  // ---------------- Control registers ----------------
  always_comb begin
    nxt_irqEn = irqEn_ff;
    nxt_cont = cont_ff;
    nxt_chan = chan_ff;
    nxt_trigSel = trigSel_ff;
    nxt_cmpEn = cmpEn_ff;
    nxt_cmpGe = cmpGe_ff;
    nxt_compare = compare_ff;
    nxt_mode = mode_ff;
    nxt_irqMask = irqMask_ff;
    if (wrSc1) begin
      nxt_irqEn = hwdata[SC1_IRQEN_BIT];
      nxt_cont = hwdata[SC1_CONT_BIT];
      nxt_chan = wrChan;
    end
    // Low four bits are reserved and never stored; software keeps them zero
    if (wrSc2) begin
      nxt_trigSel = hwdata[SC2_TRIG_BIT];
      nxt_cmpEn = hwdata[SC2_CMPEN_BIT];
      nxt_cmpGe = hwdata[SC2_CMPGE_BIT];
    end
    if (wrCompare) begin
      nxt_compare = hwdata[RESULT_W-1:0];
    end
    if (wrMode) begin
      nxt_mode = hwdata[1:0];
    end
    if (wrIrqMask) begin
      nxt_irqMask = hwdata[IRQ_W-1:0];
    end
  end

  // ---------------- Interrupts ----------------
  always_comb begin
    irqEvents = '0;
    irqEvents[IRQ_DONE_BIT] = accepted && irqEn_ff;
    irqEvents[IRQ_LOST_BIT] = accepted && interlock_ff;
    nxt_irqStatus = irqStatus_ff;
    if (wrIrqStatus) begin
      nxt_irqStatus = irqStatus_ff & ~hwdata[IRQ_W-1:0];
    end
    nxt_irqStatus = nxt_irqStatus | irqEvents;
  end

  assign irq = |(irqStatus_ff & irqMask_ff);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_ff <= SC1_RESET[SC1_FLAG_BIT];
      irqEn_ff <= SC1_RESET[SC1_IRQEN_BIT];
      cont_ff <= SC1_RESET[SC1_CONT_BIT];
      chan_ff <= SC1_RESET[SC1_CHAN_MSB:0];
      trigSel_ff <= SC2_RESET[2];
      cmpEn_ff <= SC2_RESET[1];
      cmpGe_ff <= SC2_RESET[0];
      compare_ff <= COMPARE_RESET;
      mode_ff <= MODE_RESET;
      result_ff <= '0;
      interlock_ff <= 1'b0;
      irqStatus_ff <= '0;
      irqMask_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
      irqEn_ff <= nxt_irqEn;
      cont_ff <= nxt_cont;
      chan_ff <= nxt_chan;
      trigSel_ff <= nxt_trigSel;
      cmpEn_ff <= nxt_cmpEn;
      cmpGe_ff <= nxt_cmpGe;
      compare_ff <= nxt_compare;
      mode_ff <= nxt_mode;
      result_ff <= nxt_result;
      interlock_ff <= nxt_interlock;
      irqStatus_ff <= nxt_irqStatus;
      irqMask_ff <= nxt_irqMask;
    end
  end

  // ---------------- Conversion sequencer ----------------
  always_comb begin
    nxt_state = state_ff;
    nxt_convCtl = '0;
    case (state_ff)
      ST_IDLE: begin
        if (wrSc1) begin
          if (wrChan != CHAN_OFF && !trigSel_ff) begin
            nxt_state = ST_CONV;
            nxt_convCtl.start = 1'b1;
          end
        end else if (trgEdge && trigSel_ff && chan_ff != CHAN_OFF) begin
          nxt_state = ST_CONV;
          nxt_convCtl.start = 1'b1;
        end
      end
      ST_CONV: begin
        if (wrSc1) begin
          nxt_convCtl.abort = 1'b1;
          if (wrChan != CHAN_OFF && !trigSel_ff) begin
            nxt_convCtl.start = 1'b1;
          end else begin
            nxt_state = ST_IDLE;
          end
        end else if (finish) begin
          if (cont_ff && chan_ff != CHAN_OFF) begin
            nxt_convCtl.start = 1'b1;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Powered while converting or waiting in continuous mode
    nxt_convCtl.powerOn = (nxt_state == ST_CONV || nxt_cont)
                          && nxt_chan != CHAN_OFF;
    nxt_convCtl.lowPower = !nxt_convCtl.powerOn;
  end

  always_comb begin
    nxt_route = '0;
    nxt_route.index = chan_ff;
    if (chan_ff <= CHAN_LAST_INPUT) begin
      nxt_route.inputSel = 1'b1;
    end else if (chan_ff == CHAN_REF_HIGH) begin
      nxt_route.highRef = 1'b1;
    end else if (chan_ff == CHAN_REF_LOW) begin
      nxt_route.lowRef = 1'b1;
    end else if (chan_ff == CHAN_RESERVED) begin
      nxt_route.reserved = 1'b1;
    end else begin
      nxt_route.isolate = 1'b1;
    end
  end

  assign convCtl = convCtl_ff;
  assign chanRoute = route_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      convCtl_ff <= '{start: 1'b0, abort: 1'b0, powerOn: 1'b0,
                      lowPower: 1'b1};
      route_ff <= '{inputSel: 1'b0, highRef: 1'b0, lowRef: 1'b0,
                    reserved: 1'b0, isolate: 1'b1, index: CHAN_OFF};
    end else begin
      state_ff <= nxt_state;
      convCtl_ff <= nxt_convCtl;
      route_ff <= nxt_route;
    end
  end

endmodule

`default_nettype wire

// ===== sim/adc_conversion_control_monitor.sv
// Port checker of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_monitor
  import adc_ctrl_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic hsel, // Bus
  input wire logic [31:0] haddr, // Bus
  input wire logic [1:0] htrans, // Bus
  input wire logic hwrite, // Bus
  input wire logic [2:0] hsize, // Bus
  input wire logic [31:0] hwdata, // Bus
  input wire logic hready, // Bus
  input wire logic hreadyout, // Bus
  input wire logic hresp, // Bus
  input wire logic [31:0] hrdata, // Bus
  input wire logic hwTriggerInput, // Trigger
  input wire logic convDone, // Converter
  input wire logic [RESULT_W-1:0] convData, // Converter
  input wire conv_ctl_t convCtl, // Converter
  input wire chan_route_t chanRoute, // Routing
  input wire logic irq // Interrupt
);
  typedef struct packed {
    logic sc1Ph, sc2Ph, cont, trig, busy;
    logic [4:0] chan;
  } shadow_t;
  shadow_t sh_ff, nxt_sh;
  logic take, sc1Land, sc2Land;
  // Shadow of the control bits as software last wrote them
  always_comb begin
    take = hsel && hready && htrans[1] && hwrite;
    sc1Land = sh_ff.sc1Ph && hready;
    sc2Land = sh_ff.sc2Ph && hready;
    nxt_sh = sh_ff;
    if (hready) begin
      nxt_sh.sc1Ph = take && haddr[7:0] == OFS_SC1;
      nxt_sh.sc2Ph = take && haddr[7:0] == OFS_SC2;
    end
    if (sc1Land) begin
      nxt_sh.chan = hwdata[4:0];
      nxt_sh.cont = hwdata[SC1_CONT_BIT];
    end
    if (sc2Land) begin
      nxt_sh.trig = hwdata[SC2_TRIG_BIT];
    end
    nxt_sh.busy = convCtl.start
      || (sh_ff.busy && !convDone && !convCtl.abort);
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sh_ff <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, CHAN_OFF};
    end else begin
      sh_ff <= nxt_sh;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_sw_start;
    sc1Land && hwdata[4:0] != CHAN_OFF && !sh_ff.trig |=> convCtl.start;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("no start");
  property p_abort;
    sc1Land && sh_ff.busy && !convDone |=> convCtl.abort;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_off_write;
    sc1Land && hwdata[4:0] == CHAN_OFF |=> !convCtl.start
      ##1 (chanRoute.isolate && chanRoute.index == CHAN_OFF);
  endproperty
  a_off_write: assert property (p_off_write) else $error("not off");
  property p_hw_write;
    sc1Land && sh_ff.trig |=> !convCtl.start;
  endproperty
  a_hw_write: assert property (p_hw_write) else $error("sw start");
  property p_hw_start;
    $rose(hwTriggerInput) && sh_ff.trig && sh_ff.chan != CHAN_OFF
      && !sh_ff.busy |-> ##[2:7] convCtl.start;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("hw start");
  property p_low_power;
    convDone && sh_ff.busy && !sh_ff.cont && !sc1Land
      |-> ##[1:2] convCtl.lowPower;
  endproperty
  a_low_power: assert property (p_low_power) else $error("power");
  property p_no_overlap;
    convCtl.start && !convCtl.abort |-> !sh_ff.busy;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("overlap");
  property p_decode;
    chanRoute.inputSel == (chanRoute.index <= CHAN_LAST_INPUT)
      && chanRoute.highRef == (chanRoute.index == CHAN_REF_HIGH)
      && chanRoute.lowRef == (chanRoute.index == CHAN_REF_LOW)
      && chanRoute.reserved == (chanRoute.index == CHAN_RESERVED)
      && chanRoute.isolate == (chanRoute.index == CHAN_OFF);
  endproperty
  a_decode: assert property (p_decode) else $error("decode");
  c_start: cover property (convCtl.start);
  c_abort: cover property (convCtl.abort);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ===== sim/adc_conversion_control_tb_top.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb_top;
  import adc_ctrl_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic hwTrig = 1'b0, convDone = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [RESULT_W-1:0] convData = 12'h000, nextData = 12'h000, expRes, cv;
  logic hready, hreadyout, hresp, irq, ge, t;
  logic [4:0] ch;
  conv_ctl_t convCtl;
  chan_route_t chanRoute;
  int err_total = 0, compares = 0, startCnt = 0, cnt = 0, s;
  assign hready = hreadyout;
  always #12.5 clk_sys = ~clk_sys;
  adc_conversion_control uut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hwTriggerInput(hwTrig), .convDone(convDone),
    .convData(convData), .convCtl(convCtl), .chanRoute(chanRoute),
    .irq(irq)
  );
  // Converter stand-in: done 12 cycles after each start, abort cancels
  always @(posedge clk_sys) begin
    if (convCtl.start === 1'b1) begin
      startCnt++;
      cnt = 12;
    end else if (convCtl.abort === 1'b1) begin
      cnt = 0;
    end else if (cnt != 0) begin
      cnt--;
    end
    convDone <= cnt == 1;
    convData <= nextData;
  end
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task w(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, v);
    chk("hresp", 32'h0, hresp);
  endtask
  task wait_done;
    do @(posedge clk_sys); while (convDone !== 1'b1);
    repeat (3) @(posedge clk_sys);
  endtask
  function automatic chan_route_t route(input logic [4:0] c);
    route = '{c <= CHAN_LAST_INPUT, c == CHAN_REF_HIGH, c == CHAN_REF_LOW,
      c == CHAN_RESERVED, c == CHAN_OFF, c};
  endfunction
  function automatic logic hit(input logic [11:0] r, c, input logic g);
    hit = g ? r >= c : r < c;
  endfunction
  task final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    s = $urandom(32'h1055);
    w(8'h20, 32'h45);
    rc(OFS_SC1, 32'h1f, "sc1 reset");
    rc(OFS_SC2, 32'h0, "sc2 reset");
    rc(8'h20, 32'h0, "unmapped");
    w(OFS_MODE, 32'h1);
    w(OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ch = 5'($urandom % 28);
      nextData = 12'($urandom);
      s = startCnt;
      w(OFS_SC1, {24'h0, 3'b010, ch});
      rc(OFS_SC2, 32'h80, "active");
      wait_done;
      chk("starts", s + 1, startCnt);
      chk("irq", 32'h1, irq);
      rc(OFS_SC1, {24'h0, 3'b110, ch}, "flag");
      w(OFS_IRQ_MASK, 32'h0);
      rc(OFS_SC2, 32'h0, "idle");
      chk("masked", 32'h0, irq);
      w(OFS_IRQ_MASK, 32'h1);
      w(OFS_IRQ_STATUS, 32'h1);
      rc(OFS_RESULT_HIGH, nextData[11:8], "high");
      rc(OFS_RESULT_LOW, nextData[7:0], "low");
      chk("irq clear", 32'h0, irq);
      rc(OFS_SC1, {24'h0, 3'b010, ch}, "flag clear");
    end
    expRes = nextData;
    for (int i = 0; i < 8; i++) begin
      ge = i[0];
      cv = 12'($urandom);
      nextData = (i < 2) ? cv : 12'($urandom);
      w(OFS_COMPARE, {20'h0, cv});
      w(OFS_SC2, {26'h0, 1'b1, ge, 4'h0});
      w(OFS_SC1, 32'h2);
      wait_done;
      t = hit(nextData, cv, ge);
      if (t) expRes = nextData;
      rc(OFS_SC1, {24'h0, t, 7'h2}, "cmp flag");
      rc(OFS_RESULT_HIGH, expRes[11:8], "cmp high");
      rc(OFS_RESULT_LOW, expRes[7:0], "cmp low");
    end
    w(OFS_SC2, 32'h0);
    nextData = 12'($urandom);
    rc(OFS_RESULT_HIGH, expRes[11:8], "lock high");
    w(OFS_SC1, 32'h2);
    wait_done;
    rc(OFS_RESULT_LOW, expRes[7:0], "locked low");
    rc(OFS_IRQ_STATUS, 32'h2, "lost");
    w(OFS_IRQ_STATUS, 32'h3);
    s = startCnt;
    w(OFS_SC1, 32'h25);
    repeat (3) wait_done;
    w(OFS_SC1, 32'h1f);
    repeat (2) @(posedge clk_sys);
    chk("repeat", 32'h1, startCnt >= s + 3);
    s = startCnt;
    repeat (40) @(posedge clk_sys);
    chk("stopped", s, startCnt);
    chk("off", 32'h1, {convCtl.powerOn, convCtl.lowPower});
    s = startCnt;
    w(OFS_SC1, 32'h3);
    repeat (4) @(posedge clk_sys);
    w(OFS_SC1, 32'h3);
    wait_done;
    repeat (20) @(posedge clk_sys);
    chk("restart", s + 2, startCnt);
    rc(OFS_SC1, 32'h83, "abort flag");
    // 10-bit mode masks the result; 8-bit mode has no interlock
    w(OFS_MODE, 32'h2);
    nextData = 12'($urandom);
    w(OFS_SC1, 32'h2);
    wait_done;
    rc(OFS_RESULT_HIGH, nextData[9:8], "m10 high");
    rc(OFS_RESULT_LOW, nextData[7:0], "m10 low");
    w(OFS_MODE, 32'h0);
    w(OFS_SC1, 32'h2);
    wait_done;
    rc(OFS_RESULT_HIGH, 32'h0, "m8 high");
    nextData = 12'($urandom);
    w(OFS_SC1, 32'h2);
    wait_done;
    rc(OFS_RESULT_LOW, nextData[7:0], "m8 unlocked");
    w(OFS_SC2, 32'h40);
    for (int c = 0; c < 32; c++) begin
      w(OFS_SC1, 32'(c));
      repeat (2) @(posedge clk_sys);
      chk("route", route(5'(c)), chanRoute);
    end
    s = startCnt;
    w(OFS_SC1, 32'h4);
    repeat (10) @(posedge clk_sys);
    chk("hw wait", s, startCnt);
    hwTrig <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("hw once", s + 1, startCnt);
    hwTrig <= 1'b0;
    rc(OFS_SC1, 32'h84, "hw flag");
    final_report;
  end
endmodule
bind adc_conversion_control adc_conversion_control_monitor mon (
  .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .hwTriggerInput(hwTriggerInput), .convDone(convDone),
  .convData(convData), .convCtl(convCtl), .chanRoute(chanRoute),
  .irq(irq)
);
`default_nettype wire
